// file: common/act_pkg.sv
// Constants for the auxiliary channel control and threshold block.
// Assumes an 8-bit register port and 14-bit signed auxiliary samples.
`default_nettype none
package act_pkg;
    // Register offsets
    localparam logic [7:0] ACT_OFS_AUX_CONV_CONTROL    = 8'h3C;
    localparam logic [7:0] ACT_OFS_TEMPERATURE_CONFIG  = 8'h3D;
    localparam logic [7:0] ACT_OFS_ACT_THRESHOLD_HIGH  = 8'h3E;
    localparam logic [7:0] ACT_OFS_ACT_THRESHOLD_LOW   = 8'h3F;
    localparam logic [7:0] ACT_OFS_INACT_THRESHOLD_HI  = 8'h40;
    localparam logic [7:0] ACT_OFS_INACT_THRESHOLD_LO  = 8'h41;
    localparam logic [7:0] ACT_OFS_AUX_TIMER           = 8'h42;

    // Reset values
    localparam logic [7:0] ACT_RST_AUX_CONV_CONTROL    = 8'hC0;
    localparam logic [7:0] ACT_RST_ZERO                = 8'h00;

    // Writable bit masks; reserved bits read zero
    localparam logic [7:0] ACT_MSK_AUX_CONV_CONTROL    = 8'hCF;
    localparam logic [7:0] ACT_MSK_TEMPERATURE_CONFIG  = 8'h0F;
    localparam logic [7:0] ACT_MSK_THRESHOLD_HIGH      = 8'h7F;
    localparam logic [7:0] ACT_MSK_THRESHOLD_LOW       = 8'hFC;
    localparam logic [7:0] ACT_MSK_TIMER               = 8'hFF;

    // Field positions
    localparam int ACT_BIT_CONV_EN       = 0;
    localparam int ACT_BIT_ACT_EN        = 1;
    localparam int ACT_BIT_INACT_EN      = 3;
    localparam int ACT_FMT_MSB           = 7;
    localparam int ACT_FMT_LSB           = 6;

    // Sample and threshold widths
    localparam int ACT_SAMPLE_W          = 14;
    localparam int ACT_THRESH_W          = 13;
    localparam int ACT_COUNT_W           = 4;

    // Readout formats
    localparam logic [1:0] ACT_FMT_12_ID = 2'h0;
    localparam logic [1:0] ACT_FMT_8     = 2'h1;
    localparam logic [1:0] ACT_FMT_12    = 2'h2;
    localparam logic [1:0] ACT_FMT_14_ID = 2'h3;
endpackage
`default_nettype wire

// file: rtl/act_run_counter.sv
// Consecutive-sample run counter raising a one-cycle event.
// Assumes samples arrive as single-cycle valid strobes.
`timescale 1ns/1ps
`default_nettype none
module act_run_counter
    import act_pkg::*;
#(
    parameter int COUNT_W = ACT_COUNT_W
)
(
    // Clock and reset
    input  wire logic               i_clk,
    input  wire logic               i_reset_n,
    // Sample qualification
    input  wire logic               i_valid,
    input  wire logic               i_enable,
    input  wire logic               i_hit,
    input  wire logic [COUNT_W-1:0] i_target,
    // Event
    output logic                    o_event
);
    logic [COUNT_W-1:0] count_reg;
    logic [COUNT_W-1:0] count_next;
    logic               event_next;
    wire  logic [COUNT_W-1:0] eff_target;
    wire  logic               sample_in;
    wire  logic               reach;

    // A zero count still needs one qualifying sample
    assign eff_target = (i_target == '0) ? COUNT_W'(1) : i_target;
    assign sample_in  = i_valid && i_enable;
    assign reach      = i_hit && (count_reg < eff_target) && (count_reg + COUNT_W'(1) == eff_target);

    always_comb
    begin
        count_next = count_reg;
        event_next = 1'b0;
        if (!i_enable)
        begin
            count_next = '0;
        end
        else if (sample_in)
        begin
            if (!i_hit)
            begin
                count_next = '0;
            end
            else if (count_reg < eff_target)
            begin
                count_next = count_reg + COUNT_W'(1);
                event_next = reach;
            end
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
        begin
            count_reg <= '0;
            o_event   <= 1'b0;
        end
        else
        begin
            count_reg <= count_next;
            o_event   <= event_next;
        end
    end

    a_event_needs_hit: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        o_event |-> $past(i_valid) && $past(i_enable) && $past(i_hit))
        else $error("event without a qualifying sample");

    a_single_event_run: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        o_event |=> !o_event)
        else $error("event repeated without a new run");
endmodule
`default_nettype wire

// file: rtl/act_aux_ctl.sv
// Auxiliary channel control, readout formatting and threshold detection.
// Assumes a synchronous 8-bit register port and a single sample clock.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - FIFO keeps 14-bit words; format bits 7:6 apply only at readout.
// - Format 11 gives 14 bits plus channel ID; 00 gives 12 plus ID.
// - Format 01 gives upper 8 bits; 10 gives upper 12 bits; no ID.
// - External converter runs on bit 0 unless temperature conversion is on.
// - Control bit 1 enables activity detection on external samples.
// - Control bit 3 enables inactivity detection on external samples.
// - Temperature bit 0 converts temperature with each acceleration sample.
// - Temperature bit 1 enables activity detection on temperature samples.
// - Temperature bit 3 enables inactivity detection on temperature samples.
// - Absolute 14-bit sample magnitude compared to 13-bit unsigned threshold.
// - Activity threshold is high[6:0] over low[7:2].
// - Inactivity threshold bits 12:6 come from inactivity-high bits 6:0.
// - Thresholds are raw codes, no scaling.
// - Activity event after timer[3:0] consecutive samples above threshold.
// - Inactivity event after timer[7:4] consecutive samples below threshold.
// - Inactivity threshold bits 5:0 come from register 0x41 bits 7:2.
module act_aux_ctl
    import act_pkg::*;
(
    // Clock and reset
    input  wire logic                    I_CLK,
    input  wire logic                    I_RESET_N,
    // Register port
    input  wire logic                    I_REG_WE,
    input  wire logic                    I_REG_RE,
    input  wire logic [7:0]              I_REG_ADDR,
    input  wire logic [7:0]              I_REG_WDATA,
    output logic      [7:0]              O_REG_RDATA,
    // Auxiliary samples
    input  wire logic                    I_SAMPLE_VALID,
    input  wire logic                    I_SAMPLE_IS_TEMP,
    input  wire logic [ACT_SAMPLE_W-1:0] I_SAMPLE_DATA,
    // FIFO readout
    input  wire logic                    I_FIFO_RD,
    input  wire logic [ACT_SAMPLE_W-1:0] I_FIFO_WORD,
    input  wire logic [1:0]              I_FIFO_CHAN_ID,
    output logic      [15:0]             O_FIFO_DATA,
    // Converter enables
    output logic                         O_EXT_CONV_EN,
    output logic                         O_TEMP_CONV_EN,
    // Events
    output logic                         O_ACTIVITY_EVENT,
    output logic                         O_INACTIVITY_EVENT
);
    logic [7:0]  aux_conv_control_reg;
    logic [7:0]  temperature_config_reg;
    logic [7:0]  activity_threshold_high_reg;
    logic [7:0]  activity_threshold_low_reg;
    logic [7:0]  inactivity_threshold_high_reg;
    logic [7:0]  inactivity_threshold_low_reg;
    logic [7:0]  aux_timer_reg;
    logic [7:0]  rdata_next;
    logic [15:0] fifo_next;

    wire logic [1:0]              fifo_readout_format;
    wire logic [ACT_THRESH_W-1:0] aux_activity_threshold;
    wire logic [ACT_THRESH_W-1:0] aux_inactivity_threshold;
    wire logic [ACT_SAMPLE_W-1:0] sample_mag;
    wire logic                    ext_on;
    wire logic                    act_enable;
    wire logic                    inact_enable;
    wire logic                    above_thr;
    wire logic                    below_thr;
    wire logic [ACT_COUNT_W-1:0]  aux_activity_sample_count;
    wire logic [ACT_COUNT_W-1:0]  aux_inactivity_sample_count;

    assign fifo_readout_format = aux_conv_control_reg[ACT_FMT_MSB:ACT_FMT_LSB];
    assign aux_activity_threshold = {activity_threshold_high_reg[6:0],
                                     activity_threshold_low_reg[7:2]};
    assign aux_inactivity_threshold = {inactivity_threshold_high_reg[6:0],
                                       inactivity_threshold_low_reg[7:2]};

    // Temperature wins over the external converter
    assign ext_on = aux_conv_control_reg[ACT_BIT_CONV_EN]
                    && !temperature_config_reg[ACT_BIT_CONV_EN];

    assign act_enable = I_SAMPLE_IS_TEMP ? temperature_config_reg[ACT_BIT_ACT_EN]
                                         : (aux_conv_control_reg[ACT_BIT_ACT_EN] && ext_on);
    assign inact_enable = I_SAMPLE_IS_TEMP ? temperature_config_reg[ACT_BIT_INACT_EN]
                                           : (aux_conv_control_reg[ACT_BIT_INACT_EN] && ext_on);

    // Magnitude of the signed sample; the most negative code gives 8192
    assign sample_mag = I_SAMPLE_DATA[ACT_SAMPLE_W-1] ? (~I_SAMPLE_DATA + ACT_SAMPLE_W'(1))
                                                      : I_SAMPLE_DATA;
    assign above_thr = sample_mag > {1'b0, aux_activity_threshold};
    assign below_thr = sample_mag < {1'b0, aux_inactivity_threshold};

    assign aux_activity_sample_count   = aux_timer_reg[3:0];
    assign aux_inactivity_sample_count = aux_timer_reg[7:4];

    // Register read mux, reserved bits held zero by write masks
    always_comb
    begin
        case (I_REG_ADDR)
            ACT_OFS_AUX_CONV_CONTROL:   rdata_next = aux_conv_control_reg;
            ACT_OFS_TEMPERATURE_CONFIG: rdata_next = temperature_config_reg;
            ACT_OFS_ACT_THRESHOLD_HIGH: rdata_next = activity_threshold_high_reg;
            ACT_OFS_ACT_THRESHOLD_LOW:  rdata_next = activity_threshold_low_reg;
            ACT_OFS_INACT_THRESHOLD_HI: rdata_next = inactivity_threshold_high_reg;
            ACT_OFS_INACT_THRESHOLD_LO: rdata_next = inactivity_threshold_low_reg;
            ACT_OFS_AUX_TIMER:          rdata_next = aux_timer_reg;
            default:                    rdata_next = 8'h00;
        endcase
    end

    // Readout formatting of a stored full-width word
    always_comb
    begin
        case (fifo_readout_format)
            ACT_FMT_12_ID: fifo_next = {I_FIFO_CHAN_ID, {2{I_FIFO_WORD[13]}}, I_FIFO_WORD[13:2]};
            ACT_FMT_8:     fifo_next = {8'h00, I_FIFO_WORD[13:6]};
            ACT_FMT_12:    fifo_next = {{4{I_FIFO_WORD[13]}}, I_FIFO_WORD[13:2]};
            default:       fifo_next = {I_FIFO_CHAN_ID, I_FIFO_WORD};
        endcase
    end

    always_ff @(posedge I_CLK)
    begin
        if (!I_RESET_N)
        begin
            aux_conv_control_reg          <= ACT_RST_AUX_CONV_CONTROL;
            temperature_config_reg        <= ACT_RST_ZERO;
            activity_threshold_high_reg   <= ACT_RST_ZERO;
            activity_threshold_low_reg    <= ACT_RST_ZERO;
            inactivity_threshold_high_reg <= ACT_RST_ZERO;
            inactivity_threshold_low_reg  <= ACT_RST_ZERO;
            aux_timer_reg                 <= ACT_RST_ZERO;
        end
        else if (I_REG_WE)
        begin
            case (I_REG_ADDR)
                ACT_OFS_AUX_CONV_CONTROL:   aux_conv_control_reg <= I_REG_WDATA & ACT_MSK_AUX_CONV_CONTROL;
                ACT_OFS_TEMPERATURE_CONFIG: temperature_config_reg <= I_REG_WDATA & ACT_MSK_TEMPERATURE_CONFIG;
                ACT_OFS_ACT_THRESHOLD_HIGH: activity_threshold_high_reg <= I_REG_WDATA & ACT_MSK_THRESHOLD_HIGH;
                ACT_OFS_ACT_THRESHOLD_LOW:  activity_threshold_low_reg <= I_REG_WDATA & ACT_MSK_THRESHOLD_LOW;
                ACT_OFS_INACT_THRESHOLD_HI: inactivity_threshold_high_reg <= I_REG_WDATA & ACT_MSK_THRESHOLD_HIGH;
                ACT_OFS_INACT_THRESHOLD_LO: inactivity_threshold_low_reg <= I_REG_WDATA & ACT_MSK_THRESHOLD_LOW;
                ACT_OFS_AUX_TIMER:          aux_timer_reg <= I_REG_WDATA & ACT_MSK_TIMER;
                default:                    aux_timer_reg <= aux_timer_reg;
            endcase
        end
    end

    always_ff @(posedge I_CLK)
    begin
        if (!I_RESET_N)
        begin
            O_REG_RDATA    <= 8'h00;
            O_FIFO_DATA    <= 16'h0000;
            O_EXT_CONV_EN  <= 1'b0;
            O_TEMP_CONV_EN <= 1'b0;
        end
        else
        begin
            O_REG_RDATA    <= I_REG_RE ? rdata_next : O_REG_RDATA;
            O_FIFO_DATA    <= I_FIFO_RD ? fifo_next : O_FIFO_DATA;
            O_EXT_CONV_EN  <= ext_on;
            O_TEMP_CONV_EN <= temperature_config_reg[ACT_BIT_CONV_EN];
        end
    end

    act_run_counter #(
        .COUNT_W (ACT_COUNT_W)
    ) u_activity_run (
        .i_clk     (I_CLK),
        .i_reset_n (I_RESET_N),
        .i_valid   (I_SAMPLE_VALID),
        .i_enable  (act_enable),
        .i_hit     (above_thr),
        .i_target  (aux_activity_sample_count),
        .o_event   (O_ACTIVITY_EVENT)
    );

    act_run_counter #(
        .COUNT_W (ACT_COUNT_W)
    ) u_inactivity_run (
        .i_clk     (I_CLK),
        .i_reset_n (I_RESET_N),
        .i_valid   (I_SAMPLE_VALID),
        .i_enable  (inact_enable),
        .i_hit     (below_thr),
        .i_target  (aux_inactivity_sample_count),
        .o_event   (O_INACTIVITY_EVENT)
    );

    a_ext_conv_gate: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        O_EXT_CONV_EN |-> $past(temperature_config_reg[ACT_BIT_CONV_EN]) == 1'b0)
        else $error("external converter on while temperature enabled");

    a_temp_conv_follow: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        ##1 O_TEMP_CONV_EN == $past(temperature_config_reg[ACT_BIT_CONV_EN]))
        else $error("temperature enable not following its bit");

    a_fmt_full_id: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        I_FIFO_RD && fifo_readout_format == ACT_FMT_14_ID |=> O_FIFO_DATA == {$past(I_FIFO_CHAN_ID), $past(I_FIFO_WORD)})
        else $error("full format readout wrong");

    a_fmt_eight_bit: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        I_FIFO_RD && fifo_readout_format == ACT_FMT_8 |=> O_FIFO_DATA == {8'h00, $past(I_FIFO_WORD[13:6])})
        else $error("8-bit readout wrong");

    a_fmt_twelve_id: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        I_FIFO_RD && fifo_readout_format == ACT_FMT_12_ID |=> O_FIFO_DATA[11:0] == $past(I_FIFO_WORD[13:2])
            && O_FIFO_DATA[15:14] == $past(I_FIFO_CHAN_ID))
        else $error("12-bit with id readout wrong");

    a_reserved_read_zero: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        I_REG_RE && I_REG_ADDR == ACT_OFS_ACT_THRESHOLD_LOW |=> O_REG_RDATA[1:0] == 2'h0)
        else $error("reserved bits read nonzero");

    a_act_disabled_quiet: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        I_SAMPLE_VALID && !act_enable |=> !O_ACTIVITY_EVENT)
        else $error("activity event while detection disabled");

    a_inact_disabled_quiet: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        I_SAMPLE_VALID && !inact_enable |=> !O_INACTIVITY_EVENT)
        else $error("inactivity event while detection disabled");

    a_act_threshold_cmp: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        I_SAMPLE_VALID && sample_mag <= {1'b0, aux_activity_threshold} |=> !O_ACTIVITY_EVENT)
        else $error("activity event at or below threshold");
endmodule
`default_nettype wire

// file: dv/act_host_model.sv
// Host side model driving the block's register strobe port.
// Assumes the block samples strobes on the rising edge of i_clk.
`timescale 1ns/1ps
`default_nettype none
module act_host_model
(
    // Clock
    input  wire logic       i_clk,
    // Register port
    input  wire logic [7:0] i_reg_rdata,
    output logic            o_reg_we,
    output logic            o_reg_re,
    output logic      [7:0] o_reg_addr,
    output logic      [7:0] o_reg_wdata
);
    initial
    begin
        o_reg_we    = 1'b0;
        o_reg_re    = 1'b0;
        o_reg_addr  = 8'h00;
        o_reg_wdata = 8'h00;
    end

    // Released lines show the inverse so stale values cannot match
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_reg_we    <= 1'b1;
        o_reg_addr  <= a;
        o_reg_wdata <= d;
        @(posedge i_clk);
        o_reg_we    <= 1'b0;
        o_reg_addr  <= ~a;
        o_reg_wdata <= ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clk);
        o_reg_re   <= 1'b1;
        o_reg_addr <= a;
        @(posedge i_clk);
        o_reg_re   <= 1'b0;
        o_reg_addr <= ~a;
        #1;
        d = i_reg_rdata;
    endtask
endmodule
`default_nettype wire

// file: dv/tb.sv
// Self-checking bench for the auxiliary channel control block.
// Assumes registered outputs settle one cycle after the sampling edge.
`timescale 1ns/1ps
`default_nettype none
module tb
    import act_pkg::*;
;
    logic        clk, rst_n, we, re, smp_v, smp_t, fifo_rd;
    logic [7:0]  addr, wdata, rdata, rv;
    logic [13:0] smp_d, fifo_w;
    logic [1:0]  fifo_id;
    logic [15:0] fifo_q;
    logic        ext_en, temp_en, act_ev, inact_ev;
    int          err_count, tests_run;
    logic [7:0]  msk [8] = '{8'hCF, 8'h0F, 8'h7F, 8'hFC, 8'h7F, 8'hFC, 8'hFF, 8'h00};
    logic [15:0] fexp [4] = '{16'hB8D1, 16'h008D, 16'hF8D1, 16'hA345};

    act_host_model host (.i_clk(clk), .i_reg_rdata(rdata), .o_reg_we(we), .o_reg_re(re),
                         .o_reg_addr(addr), .o_reg_wdata(wdata));

    act_aux_ctl uut (.I_CLK(clk), .I_RESET_N(rst_n), .I_REG_WE(we), .I_REG_RE(re),
                     .I_REG_ADDR(addr), .I_REG_WDATA(wdata), .O_REG_RDATA(rdata),
                     .I_SAMPLE_VALID(smp_v), .I_SAMPLE_IS_TEMP(smp_t), .I_SAMPLE_DATA(smp_d),
                     .I_FIFO_RD(fifo_rd), .I_FIFO_WORD(fifo_w), .I_FIFO_CHAN_ID(fifo_id),
                     .O_FIFO_DATA(fifo_q), .O_EXT_CONV_EN(ext_en), .O_TEMP_CONV_EN(temp_en),
                     .O_ACTIVITY_EVENT(act_ev), .O_INACTIVITY_EVENT(inact_ev));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_count++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        host.rd(a, rv);
        chk({8'h00, rv}, {8'h00, e});
    endtask

    // One sample strobe, then the event pair one cycle later
    task automatic smp(input logic t, input logic [13:0] d, input logic ea, input logic ei);
        @(posedge clk);
        smp_v <= 1'b1;
        smp_t <= t;
        smp_d <= d;
        @(posedge clk);
        smp_v <= 1'b0;
        smp_d <= ~d;
        #1;
        chk({14'h0000, act_ev, inact_ev}, {14'h0000, ea, ei});
    endtask

    task automatic test_done();
        $display("Checks %0d errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        #200000;
        err_count++;
        test_done();
    end

    initial
    begin
        err_count = 0;
        tests_run = 0;
        rst_n     = 1'b0;
        smp_v     = 1'b0;
        smp_t     = 1'b0;
        smp_d     = 14'h0000;
        fifo_rd   = 1'b0;
        fifo_w    = 14'h0000;
        fifo_id   = 2'h0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++)
            rchk(8'h3C + i[7:0], (i == 0) ? ACT_RST_AUX_CONV_CONTROL : ACT_RST_ZERO);
        for (int i = 0; i < 8; i++)
        begin
            host.wr(8'h3C + i[7:0], 8'hFF);
            rchk(8'h3C + i[7:0], msk[i]);
        end
        chk({14'h0000, ext_en, temp_en}, 16'h0001);
        host.wr(ACT_OFS_TEMPERATURE_CONFIG, 8'h00);
        @(posedge clk);
        #1;
        chk({14'h0000, ext_en, temp_en}, 16'h0002);
        for (int i = 0; i < 4; i++)
        begin
            host.wr(ACT_OFS_AUX_CONV_CONTROL, {i[1:0], 6'h00});
            @(posedge clk);
            fifo_rd <= 1'b1;
            fifo_w  <= 14'h2345;
            fifo_id <= 2'h2;
            @(posedge clk);
            fifo_rd <= 1'b0;
            fifo_w  <= 14'h1CBA;
            #1;
            chk(fifo_q, fexp[i]);
        end
        // Activity threshold 66, inactivity threshold 5, runs of 3 and 2
        host.wr(ACT_OFS_ACT_THRESHOLD_HIGH, 8'h01);
        host.wr(ACT_OFS_ACT_THRESHOLD_LOW, 8'h08);
        host.wr(ACT_OFS_INACT_THRESHOLD_HI, 8'h00);
        host.wr(ACT_OFS_INACT_THRESHOLD_LO, 8'h14);
        host.wr(ACT_OFS_AUX_TIMER, 8'h23);
        host.wr(ACT_OFS_TEMPERATURE_CONFIG, 8'h0A);
        smp(1'b1, 14'h0043, 1'b0, 1'b0);
        smp(1'b1, 14'h0043, 1'b0, 1'b0);
        smp(1'b1, 14'h3FBD, 1'b1, 1'b0);
        smp(1'b1, 14'h0042, 1'b0, 1'b0);
        smp(1'b1, 14'h0004, 1'b0, 1'b0);
        smp(1'b1, 14'h0005, 1'b0, 1'b0);
        smp(1'b1, 14'h3FFC, 1'b0, 1'b0);
        smp(1'b1, 14'h0004, 1'b0, 1'b1);
        host.wr(ACT_OFS_TEMPERATURE_CONFIG, 8'h00);
        repeat (3) smp(1'b1, 14'h0064, 1'b0, 1'b0);
        host.wr(ACT_OFS_AUX_CONV_CONTROL, 8'h0B);
        smp(1'b0, 14'h0064, 1'b0, 1'b0);
        smp(1'b0, 14'h0064, 1'b0, 1'b0);
        smp(1'b0, 14'h0064, 1'b1, 1'b0);
        smp(1'b0, 14'h0000, 1'b0, 1'b0);
        smp(1'b0, 14'h0000, 1'b0, 1'b1);
        host.wr(ACT_OFS_TEMPERATURE_CONFIG, 8'h01);
        repeat (3) smp(1'b0, 14'h0064, 1'b0, 1'b0);
        chk({14'h0000, ext_en, temp_en}, 16'h0001);
        // Zero run length counts as one sample, and a run fires only once
        host.wr(ACT_OFS_TEMPERATURE_CONFIG, 8'h0B);
        host.wr(ACT_OFS_AUX_TIMER, 8'h00);
        smp(1'b1, 14'h0043, 1'b1, 1'b0);
        smp(1'b1, 14'h0043, 1'b0, 1'b0);
        smp(1'b1, 14'h0000, 1'b0, 1'b1);
        test_done();
    end
endmodule
`default_nettype wire
